// ==== hw/tsc_regs.sv ====
// Touch sensor configuration register bank behind a serial two-wire slave port
`timescale 1ns/100ps
`include "tsc_consts.svh"

// Behaviour
// - Writing one to filter bit 7 resets all baselines; bit self-clears.
// - Filter bit 5 set drops samples taken while bus traffic was active.
// - Filter bit 4 switches the raw-count averaging filter on or off.
// - Averaging order 00 averages two samples, 01 averages four samples.
// - Single-bit scan position registers accept writes only in setup mode.
// - Per-sensor eight-bit touch threshold resets to 64h; host keeps 3..255.
// - Sensitivity current written as zero is replaced by ten.
// - Bytes 3Ch, A5h, 69h to lock register unlock the address register.
// - Bytes 96h, 5Ah, C3h to lock register relock the address register.
// - Lock register bit 0 reads one when locked, zero when unlocked.
// - Writes to the address register while locked are ignored.
// - New address and pull-up setting apply only after relocking.
// - Address bit 7 disables pull-ups when one; bits 6:0 are slave address.
// - Read-only product identification register returns a fixed code.
// - Condition bits 7:6 report the detected supply range.
// - Condition bit 5 reads one after an internal reset.
// - Condition bit 4 reads one when factory settings were loaded.
// - Condition bit 3 set blocks every nonvolatile write.
// - Condition bits 1 and 0 report sensing and output functions enabled.
// - Command 08h enters setup mode, 07h enters normal mode.
module tsc_regs
    import tsc_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // Serial bus pins
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe,
    // Device state inputs
    input  wire tsc_cond_s   cond_in,
    // Sensing core samples
    input  wire logic        sample_start,
    input  wire logic        sample_done,
    input  wire logic [15:0] raw_count,
    // Configuration to the sensing core
    output tsc_filter_s      filter_cfg,
    output logic             scan_position_0,
    output logic             scan_position_1,
    output logic [7:0]       touch_threshold_0,
    output logic [7:0]       touch_threshold_1,
    output logic [7:0]       sensitivity_current_0,
    output logic [7:0]       sensitivity_current_1,
    output logic             setup_mode,
    // Averaged sample stream
    output logic             avg_valid,
    output logic [15:0]      avg_count,
    // Applied serial port settings and bus activity
    output logic [6:0]       slave_address,
    output logic             pullup_disable,
    output logic             bus_active,
    // Nonvolatile write request
    output logic             nv_write_req,
    output logic [7:0]       nv_write_cmd
);

    // Pin synchronisers and edge history
    logic        scl_m_q, scl_s_q, scl_p_q;
    logic        sda_m_q, sda_s_q, sda_p_q;
    // Serial engine state
    tsc_state_e  st_q, st_d;
    tsc_phase_e  ph_q, ph_d;
    logic [3:0]  bit_q, bit_d;
    logic [7:0]  sh_q, sh_d;
    logic [7:0]  ptr_q, ptr_d;
    logic        rw_q, rw_d;
    logic        oe_q, oe_d;
    logic        nack_q, nack_d;
    tsc_write_s  wr_q, wr_d;
    logic [7:0]  rd_data;
    logic        scl_rise, scl_fall, start_cond, stop_cond;
    // Register state
    tsc_filter_s flt_q, flt_d;
    logic        scan0_q, scan0_d, scan1_q, scan1_d;
    logic [7:0]  th0_q, th0_d, th1_q, th1_d;
    logic [7:0]  sc0_q, sc0_d, sc1_q, sc1_d;
    logic        lock_q, lock_d;
    logic [1:0]  unl_stg_q, unl_stg_d, lck_stg_q, lck_stg_d;
    logic [7:0]  pend_q, pend_d, live_q, live_d;
    logic        setup_q, setup_d;
    logic        nvreq_q, nvreq_d;
    logic [7:0]  nvcmd_q, nvcmd_d;
    // Sample filter state
    logic        busy_seen_q, busy_seen_d;
    logic [17:0] acc_q, acc_d;
    logic [2:0]  cnt_q, cnt_d;
    logic        av_q, av_d;
    logic [15:0] avc_q, avc_d;
    logic        keep;
    logic [2:0]  need;

    // Two flops per pin before use; the third flop gives edge history
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_m_q <= scl_i;
            scl_s_q <= scl_m_q;
            scl_p_q <= scl_s_q;
            sda_m_q <= sda_i;
            sda_s_q <= sda_m_q;
            sda_p_q <= sda_s_q;
        end
    end

    // Bus events decoded from synchronised levels
    assign scl_rise   = scl_s_q & ~scl_p_q;
    assign scl_fall   = ~scl_s_q & scl_p_q;
    assign start_cond = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
    assign stop_cond  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

    // Read data mux; reserved bits read as zero
    always_comb begin
        case (ptr_q)
            `TSC_OFF_FILTER:     rd_data = {flt_q.baseline_force_reset, 1'b0,
                                            flt_q.bus_busy_sample_drop, flt_q.avg_en,
                                            2'h0, flt_q.avg_order};
            `TSC_OFF_SCAN0:      rd_data = {7'h00, scan0_q};
            `TSC_OFF_SCAN1:      rd_data = {7'h00, scan1_q};
            `TSC_OFF_THRESH0:    rd_data = th0_q;
            `TSC_OFF_THRESH1:    rd_data = th1_q;
            `TSC_OFF_SENS0:      rd_data = sc0_q;
            `TSC_OFF_SENS1:      rd_data = sc1_q;
            `TSC_OFF_LOCK:       rd_data = {7'h00, lock_q};
            `TSC_OFF_PRODUCT:    rd_data = `TSC_PRODUCT_CODE;
            `TSC_OFF_CONDITION:  rd_data = {cond_in.supply_range,
                                            cond_in.internal_reset_flag,
                                            cond_in.factory_settings_loaded,
                                            cond_in.nonvolatile_write_blocked,
                                            1'b0,
                                            cond_in.sensing_function_on,
                                            cond_in.output_function_on};
            `TSC_OFF_ADDR_DRIVE: rd_data = pend_q;
            default:             rd_data = 8'h00;
        endcase
    end

    // Serial slave engine: address match, pointer byte, then data bytes
    always_comb begin
        st_d   = st_q;
        ph_d   = ph_q;
        bit_d  = bit_q;
        sh_d   = sh_q;
        ptr_d  = ptr_q;
        rw_d   = rw_q;
        oe_d   = oe_q;
        nack_d = nack_q;
        wr_d   = '0;
        if (start_cond) begin
            st_d = TSC_ST_RX;
            ph_d = TSC_PH_ADDR;
            bit_d = 4'h0;
            oe_d = 1'b0;
        end else if (stop_cond) begin
            st_d = TSC_ST_IDLE;
            oe_d = 1'b0;
        end else begin
            case (st_q)
                TSC_ST_IDLE: begin
                    oe_d = 1'b0;
                end
                TSC_ST_RX: begin
                    if (scl_rise) begin
                        sh_d  = {sh_q[6:0], sda_s_q};
                        bit_d = bit_q + 4'h1;
                    end else if (scl_fall && bit_q == 4'h8) begin
                        bit_d = 4'h0;
                        case (ph_q)
                            TSC_PH_ADDR: begin
                                if (sh_q[7:1] == live_q[6:0]) begin
                                    rw_d = sh_q[0];
                                    ph_d = TSC_PH_PTR;
                                    oe_d = 1'b1;
                                    st_d = TSC_ST_RX_ACK;
                                end else begin
                                    st_d = TSC_ST_IDLE;
                                end
                            end
                            TSC_PH_PTR: begin
                                ptr_d = sh_q;
                                ph_d  = TSC_PH_DATA;
                                oe_d  = 1'b1;
                                st_d  = TSC_ST_RX_ACK;
                            end
                            default: begin
                                // Every data byte is acknowledged, even if ignored
                                wr_d.en   = 1'b1;
                                wr_d.addr = ptr_q;
                                wr_d.data = sh_q;
                                ptr_d = ptr_q + 8'h01;
                                oe_d  = 1'b1;
                                st_d  = TSC_ST_RX_ACK;
                            end
                        endcase
                    end
                end
                TSC_ST_RX_ACK: begin
                    if (scl_fall) begin
                        if (rw_q) begin
                            sh_d  = rd_data;
                            ptr_d = ptr_q + 8'h01;
                            oe_d  = ~rd_data[7];
                            bit_d = 4'h0;
                            st_d  = TSC_ST_TX;
                        end else begin
                            oe_d = 1'b0;
                            st_d = TSC_ST_RX;
                        end
                    end
                end
                TSC_ST_TX: begin
                    if (scl_fall) begin
                        if (bit_q == 4'h7) begin
                            oe_d = 1'b0;
                            st_d = TSC_ST_TX_ACK;
                        end else begin
                            sh_d  = {sh_q[6:0], 1'b0};
                            oe_d  = ~sh_q[6];
                            bit_d = bit_q + 4'h1;
                        end
                    end
                end
                TSC_ST_TX_ACK: begin
                    if (scl_rise) begin
                        nack_d = sda_s_q;
                    end else if (scl_fall) begin
                        if (nack_q) begin
                            st_d = TSC_ST_IDLE;
                        end else begin
                            sh_d  = rd_data;
                            ptr_d = ptr_q + 8'h01;
                            oe_d  = ~rd_data[7];
                            bit_d = 4'h0;
                            st_d  = TSC_ST_TX;
                        end
                    end
                end
                default: begin
                    st_d = TSC_ST_IDLE;
                    oe_d = 1'b0;
                end
            endcase
        end
    end

    // Serial engine registers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_q   <= TSC_ST_IDLE;
            ph_q   <= TSC_PH_ADDR;
            bit_q  <= 4'h0;
            sh_q   <= 8'h00;
            ptr_q  <= 8'h00;
            rw_q   <= 1'b0;
            oe_q   <= 1'b0;
            nack_q <= 1'b0;
            wr_q   <= '0;
        end else begin
            st_q   <= st_d;
            ph_q   <= ph_d;
            bit_q  <= bit_d;
            sh_q   <= sh_d;
            ptr_q  <= ptr_d;
            rw_q   <= rw_d;
            oe_q   <= oe_d;
            nack_q <= nack_d;
            wr_q   <= wr_d;
        end
    end

    // Register writes, lock sequencing and command decode
    always_comb begin
        flt_d     = flt_q;
        flt_d.baseline_force_reset = 1'b0;
        scan0_d   = scan0_q;
        scan1_d   = scan1_q;
        th0_d     = th0_q;
        th1_d     = th1_q;
        sc0_d     = sc0_q;
        sc1_d     = sc1_q;
        lock_d    = lock_q;
        unl_stg_d = unl_stg_q;
        lck_stg_d = lck_stg_q;
        pend_d    = pend_q;
        live_d    = live_q;
        setup_d   = setup_q;
        nvreq_d   = 1'b0;
        nvcmd_d   = nvcmd_q;
        if (wr_q.en) begin
            case (wr_q.addr)
                `TSC_OFF_FILTER: begin
                    flt_d.baseline_force_reset = wr_q.data[`TSC_FLT_BASELINE];
                    flt_d.bus_busy_sample_drop = wr_q.data[`TSC_FLT_DROP];
                    flt_d.avg_en               = wr_q.data[`TSC_FLT_AVG];
                    flt_d.avg_order            = wr_q.data[1:0];
                end
                `TSC_OFF_SCAN0: begin
                    if (setup_q) scan0_d = wr_q.data[0];
                end
                `TSC_OFF_SCAN1: begin
                    if (setup_q) scan1_d = wr_q.data[0];
                end
                `TSC_OFF_THRESH0: th0_d = wr_q.data;
                `TSC_OFF_THRESH1: th1_d = wr_q.data;
                `TSC_OFF_SENS0: sc0_d = (wr_q.data == 8'h00) ? `TSC_RST_SENS : wr_q.data;
                `TSC_OFF_SENS1: sc1_d = (wr_q.data == 8'h00) ? `TSC_RST_SENS : wr_q.data;
                `TSC_OFF_LOCK: begin
                    // A wrong byte restarts the sequence, or begins it anew
                    case (unl_stg_q)
                        2'h1:    unl_stg_d = (wr_q.data == `TSC_UNLOCK_B1) ? 2'h2 : 2'h0;
                        2'h2:    unl_stg_d = 2'h0;
                        default: unl_stg_d = 2'h0;
                    endcase
                    if (unl_stg_q == 2'h2 && wr_q.data == `TSC_UNLOCK_B2) begin
                        lock_d = 1'b0;
                    end else if (unl_stg_d == 2'h0 && wr_q.data == `TSC_UNLOCK_B0) begin
                        unl_stg_d = 2'h1;
                    end
                    case (lck_stg_q)
                        2'h1:    lck_stg_d = (wr_q.data == `TSC_LOCK_B1) ? 2'h2 : 2'h0;
                        2'h2:    lck_stg_d = 2'h0;
                        default: lck_stg_d = 2'h0;
                    endcase
                    if (lck_stg_q == 2'h2 && wr_q.data == `TSC_LOCK_B2) begin
                        lock_d = 1'b1;
                        live_d = pend_q;
                    end else if (lck_stg_d == 2'h0 && wr_q.data == `TSC_LOCK_B0) begin
                        lck_stg_d = 2'h1;
                    end
                end
                `TSC_OFF_ADDR_DRIVE: begin
                    if (!lock_q) pend_d = wr_q.data;
                end
                `TSC_OFF_COMMAND: begin
                    if (wr_q.data == `TSC_CMD_SETUP) setup_d = 1'b1;
                    if (wr_q.data == `TSC_CMD_NORMAL) setup_d = 1'b0;
                    // Store requests die here when condition bit 3 blocks nonvolatile writes
                    if ((wr_q.data == `TSC_CMD_STORE || wr_q.data == `TSC_CMD_WRITE_POR)
                        && !cond_in.nonvolatile_write_blocked) begin
                        nvreq_d = 1'b1;
                        nvcmd_d = wr_q.data;
                    end
                end
                default: ;
            endcase
        end
    end

    // Register bank flops
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            flt_q     <= `TSC_RST_FLT_CFG;
            scan0_q   <= `TSC_RST_SCAN0;
            scan1_q   <= `TSC_RST_SCAN1;
            th0_q     <= `TSC_RST_THRESH;
            th1_q     <= `TSC_RST_THRESH;
            sc0_q     <= `TSC_RST_SENS;
            sc1_q     <= `TSC_RST_SENS;
            lock_q    <= `TSC_RST_LOCK;
            unl_stg_q <= 2'h0;
            lck_stg_q <= 2'h0;
            pend_q    <= `TSC_RST_ADDR_DRIVE;
            live_q    <= `TSC_RST_ADDR_DRIVE;
            setup_q   <= 1'b0;
            nvreq_q   <= 1'b0;
            nvcmd_q   <= 8'h00;
        end else begin
            flt_q     <= flt_d;
            scan0_q   <= scan0_d;
            scan1_q   <= scan1_d;
            th0_q     <= th0_d;
            th1_q     <= th1_d;
            sc0_q     <= sc0_d;
            sc1_q     <= sc1_d;
            lock_q    <= lock_d;
            unl_stg_q <= unl_stg_d;
            lck_stg_q <= lck_stg_d;
            pend_q    <= pend_d;
            live_q    <= live_d;
            setup_q   <= setup_d;
            nvreq_q   <= nvreq_d;
            nvcmd_q   <= nvcmd_d;
        end
    end

    // Sample gating and averaging; orders above 01 average four samples
    always_comb begin
        need        = (flt_q.avg_order == 2'h0) ? 3'h2 : 3'h4;
        keep        = sample_done &
                      ~(flt_q.bus_busy_sample_drop & (busy_seen_q | bus_active));
        busy_seen_d = sample_start ? bus_active : (busy_seen_q | bus_active);
        acc_d       = acc_q;
        cnt_d       = cnt_q;
        av_d        = 1'b0;
        avc_d       = avc_q;
        if (keep) begin
            if (!flt_q.avg_en) begin
                av_d  = 1'b1;
                avc_d = raw_count;
                acc_d = 18'h00000;
                cnt_d = 3'h0;
            end else if (cnt_q + 3'h1 >= need) begin
                av_d  = 1'b1;
                acc_d = 18'h00000;
                cnt_d = 3'h0;
                avc_d = (need == 3'h2) ? 16'((acc_q + {2'h0, raw_count}) >> 1)
                                       : 16'((acc_q + {2'h0, raw_count}) >> 2);
            end else begin
                acc_d = acc_q + {2'h0, raw_count};
                cnt_d = cnt_q + 3'h1;
            end
        end
    end

    // Sample filter flops
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            busy_seen_q <= 1'b0;
            acc_q       <= 18'h00000;
            cnt_q       <= 3'h0;
            av_q        <= 1'b0;
            avc_q       <= 16'h0000;
        end else begin
            busy_seen_q <= busy_seen_d;
            acc_q       <= acc_d;
            cnt_q       <= cnt_d;
            av_q        <= av_d;
            avc_q       <= avc_d;
        end
    end

    // Output drive; the data pin is open drain, so only the enable moves
    assign sda_o                 = 1'b0;
    assign sda_oe                = oe_q;
    assign bus_active            = (st_q != TSC_ST_IDLE);
    assign filter_cfg            = flt_q;
    assign scan_position_0       = scan0_q;
    assign scan_position_1       = scan1_q;
    assign touch_threshold_0     = th0_q;
    assign touch_threshold_1     = th1_q;
    assign sensitivity_current_0 = sc0_q;
    assign sensitivity_current_1 = sc1_q;
    assign setup_mode            = setup_q;
    assign avg_valid             = av_q;
    assign avg_count             = avc_q;
    assign slave_address         = live_q[6:0];
    assign pullup_disable        = live_q[7];
    assign nv_write_req          = nvreq_q;
    assign nv_write_cmd          = nvcmd_q;

endmodule

// ==== hw/tsc_consts.svh ====
// Register offsets, field positions, reset values and codes of the touch config bank
`ifndef TSC_CONSTS_SVH
`define TSC_CONSTS_SVH

// Register offsets (byte pointer on the serial port)
`define TSC_OFF_FILTER     8'h56
`define TSC_OFF_SCAN0      8'h5c
`define TSC_OFF_SCAN1      8'h5d
`define TSC_OFF_THRESH0    8'h66
`define TSC_OFF_THRESH1    8'h67
`define TSC_OFF_SENS0      8'h70
`define TSC_OFF_SENS1      8'h71
`define TSC_OFF_LOCK       8'h79
`define TSC_OFF_PRODUCT    8'h7a
`define TSC_OFF_CONDITION  8'h7b
`define TSC_OFF_ADDR_DRIVE 8'h7c
`define TSC_OFF_COMMAND    8'ha0

// Filter control field positions
`define TSC_FLT_BASELINE   7
`define TSC_FLT_DROP       5
`define TSC_FLT_AVG        4

// Reset values
`define TSC_RST_FILTER     8'h20
`define TSC_RST_FLT_CFG    5'h08
`define TSC_RST_THRESH     8'h64
`define TSC_RST_SENS       8'h0a
`define TSC_RST_SCAN0      1'h0
`define TSC_RST_SCAN1      1'h1
`define TSC_RST_LOCK       1'h0
`define TSC_RST_ADDR_DRIVE 8'h00
// Arbitrary product code, not tied to any real part
`define TSC_PRODUCT_CODE   8'h3e

// Lock sequence bytes
`define TSC_UNLOCK_B0      8'h3c
`define TSC_UNLOCK_B1      8'ha5
`define TSC_UNLOCK_B2      8'h69
`define TSC_LOCK_B0        8'h96
`define TSC_LOCK_B1        8'h5a
`define TSC_LOCK_B2        8'hc3

// Command codes
`define TSC_CMD_STORE      8'h01
`define TSC_CMD_WRITE_POR  8'h03
`define TSC_CMD_NORMAL     8'h07
`define TSC_CMD_SETUP      8'h08

`endif

// ==== hw/tsc_pkg.sv ====
// Types shared by the touch config register bank
package tsc_pkg;

    typedef enum logic [2:0] {
        TSC_ST_IDLE   = 3'b000,
        TSC_ST_RX     = 3'b001,
        TSC_ST_RX_ACK = 3'b010,
        TSC_ST_TX     = 3'b011,
        TSC_ST_TX_ACK = 3'b100
    } tsc_state_e;

    typedef enum logic [1:0] {
        TSC_PH_ADDR = 2'b00,
        TSC_PH_PTR  = 2'b01,
        TSC_PH_DATA = 2'b10
    } tsc_phase_e;

    // One register write from the serial engine
    typedef struct packed {
        logic       en;
        logic [7:0] addr;
        logic [7:0] data;
    } tsc_write_s;

    // Filtering controls seen by the sensing core
    typedef struct packed {
        logic       baseline_force_reset;
        logic       bus_busy_sample_drop;
        logic       avg_en;
        logic [1:0] avg_order;
    } tsc_filter_s;

    // Device state reported in the condition register
    typedef struct packed {
        logic [1:0] supply_range;
        logic       internal_reset_flag;
        logic       factory_settings_loaded;
        logic       nonvolatile_write_blocked;
        logic       sensing_function_on;
        logic       output_function_on;
    } tsc_cond_s;

endpackage

// ==== sim/tsc_regs_sva.sv ====
// Port checker for the touch config register bank
`timescale 1ns/100ps
module tsc_regs_sva
    import tsc_pkg::*;
(
    // Clock, reset and inputs
    input wire logic        core_clk,
    input wire logic        rst,
    input wire tsc_cond_s   cond_in,
    input wire logic        sample_done,
    // Watched outputs
    input wire tsc_filter_s filter_cfg,
    input wire logic        scan_position_0,
    input wire logic [7:0]  sensitivity_current_0,
    input wire logic        setup_mode,
    input wire logic        avg_valid,
    input wire logic [6:0]  slave_address,
    input wire logic        bus_active,
    input wire logic        nv_write_req
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // Pulse width, sample gating, register guards, and settings that move only after a bus byte
    a_baseline_pulse: assert property (filter_cfg.baseline_force_reset |=>
        !filter_cfg.baseline_force_reset) else $error("baseline reset too long");
    a_drop_busy: assert property (sample_done && bus_active &&
        filter_cfg.bus_busy_sample_drop |=> !avg_valid) else $error("busy sample kept");
    a_avg_cause: assert property ($rose(avg_valid) |-> $past(sample_done))
        else $error("average without sample");
    a_sens_nonzero: assert property (sensitivity_current_0 != 8'h00) else $error("zero current");
    a_scan_setup: assert property (!$stable(scan_position_0) |-> setup_mode)
        else $error("scan moved in normal mode");
    a_addr_bus: assert property (!$stable(slave_address) |-> bus_active)
        else $error("address moved off bus");
    a_nv_block: assert property (nv_write_req |-> !cond_in.nonvolatile_write_blocked)
        else $error("blocked store issued");
    a_mode_cmd: assert property ($changed(setup_mode) |-> $past(bus_active, 2))
        else $error("mode moved off bus");
    // Main scenarios reached
    c_avg: cover property (avg_valid);
    c_setup: cover property ($rose(setup_mode));
    c_base: cover property (filter_cfg.baseline_force_reset);
endmodule

bind tsc_regs tsc_regs_sva i_sva (.*);

// ==== sim/tsc_host.sv ====
// Serial bus host model: clock and open-drain data driver
`timescale 1ns/100ps
module tsc_host (
    // Clock and wired data level
    input  wire logic core_clk,
    input  wire logic sda,
    // Host drive; one on sda_h releases the line to its pull-up
    output logic      scl = 1'b1,
    output logic      sda_h = 1'b1
);
    // Ten clocks per phase, far above the pin synchroniser delay
    task automatic step(input logic c, input logic d);
        scl <= c;
        sda_h <= d;
        repeat (10) @(posedge core_clk);
    endtask
    // scl/sda pairs: start 01_11_10_00, stop 00_10_11_11
    task automatic frame(input logic [7:0] p);
        for (int i = 3; i >= 0; i--) step(p[2*i+1], p[2*i]);
    endtask
    // Data moves only with scl low: no false start or stop
    task automatic xfer(input logic [8:0] b, output logic [7:0] q);
        for (int i = 8; i >= 0; i--) begin
            step(1'b0, b[i]);
            step(1'b1, b[i]);
            if (i > 0) q = {q[6:0], sda};
            step(1'b0, b[i]);
        end
    endtask
    // Write one byte, or read one byte after a repeated start and NACK it
    task automatic xact(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
                        input logic rd, output logic [7:0] q);
        frame(8'b01_11_10_00);
        xfer({a, 2'b01}, q);
        xfer({p, 1'b1}, q);
        if (rd) frame(8'b01_11_10_00);
        if (rd) xfer({a, 2'b11}, q);
        xfer({rd ? 8'hff : d, 1'b1}, q);
        frame(8'b00_10_11_11);
    endtask
endmodule

// ==== sim/tb_touch_sensor_config_regs.sv ====
// Self-checking bench for the touch config register bank
`timescale 1ns/100ps
`include "tsc_consts.svh"
module tb_touch_sensor_config_regs
    import tsc_pkg::*;
;
    // Inputs; condition 55h: supply 10, reset flag, store block, output on
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic        scl_i, sda_h, sample_start = 1'b0, sample_done = 1'b0;
    logic [15:0] raw_count = 16'h0000;
    tsc_cond_s   cond_in = 7'h55;
    // Design outputs and bench state
    logic        sda_o, sda_oe, scan_position_0, scan_position_1, setup_mode, avg_valid;
    logic        pullup_disable, bus_active, nv_write_req;
    tsc_filter_s filter_cfg;
    logic [7:0]  touch_threshold_0, touch_threshold_1, sensitivity_current_0, q;
    logic [7:0]  sensitivity_current_1, nv_write_cmd;
    logic [15:0] avg_count;
    logic [6:0]  slave_address;
    int          failures = 0;
    int          samples_checked = 0;
    wire         sda_i = sda_h & ~sda_oe;
    // Rows: pointer, byte written, byte read back
    logic [23:0] rows [6] = '{24'h56_90_10, 24'h66_03_03, 24'h67_ff_ff, 24'h70_00_0a,
                              24'h5c_01_01, {`TSC_OFF_PRODUCT, 8'h00, `TSC_PRODUCT_CODE}};
    logic [7:0]  lseq [6] = '{8'h3c, 8'ha5, 8'h69, 8'h96, 8'h5a, 8'hc3};
    tsc_regs i_dut (.*);
    tsc_host i_host (.core_clk, .sda(sda_i), .scl(scl_i), .sda_h);
    always #25 core_clk = ~core_clk;
    // Compare and verdict
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // One scan: start pulse, then done with its count
    task automatic smp(input logic [15:0] r);
        repeat (99) @(posedge core_clk);
        sample_start <= 1'b1;
        @(posedge core_clk);
        sample_start <= 1'b0;
        sample_done <= 1'b1;
        raw_count <= r;
        @(posedge core_clk);
        sample_done <= 1'b0;
    endtask
    // Hang guard
    initial begin
        repeat (90000) @(posedge core_clk);
        failures++;
        close_out();
    end
    // Main sequence
    initial begin
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        chk(filter_cfg, 5'b01000);
        chk(touch_threshold_1, 8'h64);
        // Sample taken mid-command is dropped
        fork
            i_host.xact(7'h00, `TSC_OFF_COMMAND, `TSC_CMD_SETUP, 1'b0, q);
            smp(16'h0100);
        join
        chk(setup_mode, 1'b1);
        chk(avg_count, 16'h0000);
        $display("setup done");
        foreach (rows[i]) begin
            i_host.xact(7'h00, rows[i][23:16], rows[i][15:8], 1'b0, q);
            i_host.xact(7'h00, rows[i][23:16], 8'h00, 1'b1, q);
            chk(q, rows[i][7:0]);
            $display("row %0d done", i);
        end
        smp(16'h0010);
        smp(16'h0030);
        for (int i = 0; i < 9 && avg_valid !== 1'b1; i++) @(negedge core_clk);
        chk(avg_count, 16'h0020);
        i_host.xact(7'h00, `TSC_OFF_COMMAND, `TSC_CMD_NORMAL, 1'b0, q);
        i_host.xact(7'h00, `TSC_OFF_SCAN0, 8'h00, 1'b0, q);
        chk(scan_position_0, 1'b1);
        foreach (lseq[i]) begin
            if (i == 3) i_host.xact(7'h00, `TSC_OFF_ADDR_DRIVE, 8'hab, 1'b0, q);
            i_host.xact(7'h00, `TSC_OFF_LOCK, lseq[i], 1'b0, q);
        end
        chk({pullup_disable, slave_address}, 8'hab);
        i_host.xact(7'h2b, `TSC_OFF_ADDR_DRIVE, 8'h11, 1'b0, q);
        i_host.xact(7'h2b, `TSC_OFF_LOCK, 8'h00, 1'b1, q);
        chk(q, 8'h01);
        i_host.xact(7'h2b, `TSC_OFF_ADDR_DRIVE, 8'h00, 1'b1, q);
        chk(q, 8'hab);
        i_host.xact(7'h2b, `TSC_OFF_CONDITION, 8'h00, 1'b1, q);
        chk(q, 8'ha9);
        i_host.xact(7'h2b, `TSC_OFF_COMMAND, `TSC_CMD_STORE, 1'b0, q);
        $display("lock done");
        close_out();
    end
endmodule
